// ### include/iob_defines.svh
`ifndef IOB_DEFINES_SVH
`define IOB_DEFINES_SVH

// bus geometry
`define IOB_ADDR_W      16
`define IOB_DATA_W      16
`define IOB_MEM_ADDR_W  15
`define IOB_WB_BIT      15
`define IOB_IO_BYTE_W   8
`define IOB_DEV_W       5
`define IOB_BYTE_SEL    1'b1

// bus cycle phase lengths, in ns, and their clock counts
`define IOB_CLK_NS      8
`define IOB_SETUP_NS    100
`define IOB_STROBE_NS   200
`define IOB_HOLD_NS     100
`define IOB_TIMER_W     8
`define IOB_SETUP_CYC   ((`IOB_SETUP_NS + `IOB_CLK_NS - 1) / `IOB_CLK_NS)
`define IOB_STROBE_CYC  ((`IOB_STROBE_NS + `IOB_CLK_NS - 1) / `IOB_CLK_NS)
`define IOB_HOLD_CYC    ((`IOB_HOLD_NS + `IOB_CLK_NS - 1) / `IOB_CLK_NS)

`endif

// ### include/iob_pkg.sv
`include "iob_defines.svh"

package iob_pkg;

  typedef enum logic [3:0] {
    IOB_OP_MEM_RD,
    IOB_OP_MEM_WR,
    IOB_OP_SELECT,
    IOB_OP_SENSE,
    IOB_OP_IO_IN,
    IOB_OP_IO_OUT,
    IOB_OP_BLK_IN,
    IOB_OP_BLK_OUT
  } iob_op_t;

  typedef enum logic [2:0] {
    IOB_ST_IDLE,
    IOB_ST_ISSUE,
    IOB_ST_SETUP,
    IOB_ST_STROBE,
    IOB_ST_HOLD,
    IOB_ST_DMA
  } iob_state_t;

  typedef struct packed {
    iob_state_t                  st;
    iob_op_t                     op;
    logic                        byte_m;
    logic                        pack;
    logic                        eob;
    logic                        reg_sel;
    logic [`IOB_MEM_ADDR_W-1:0]  mem_a;
    logic [`IOB_IO_BYTE_W-1:0]   io_sel;
    logic [`IOB_DATA_W-1:0]      wdata;
    logic [15:0]                 count;
    logic                        phase_mem;
    logic                        cur_io;
    logic                        cur_wr;
    logic [`IOB_TIMER_W-1:0]     timer;
    logic [`IOB_ADDR_W-1:0]      addr;
    logic                        addr_oe_n;
    logic [`IOB_DATA_W-1:0]      dout;
    logic                        dout_oe_n;
    logic                        sel_n;
    logic                        in_n;
    logic                        out_n;
    logic                        pulse_n;
    logic                        mrd_n;
    logic                        mwr_n;
    logic                        echo_n;
    logic                        ready;
    logic                        done;
    logic [`IOB_DATA_W-1:0]      rdata;
    logic [`IOB_DATA_W-1:0]      work_a;
    logic [`IOB_DATA_W-1:0]      work_x;
    logic                        sense;
    logic                        irq_inh;
    logic                        grant;
    logic                        dma_q1;
    logic                        dma_q2;
    logic                        ser_q1;
    logic                        ser_q2;
    logic [`IOB_DATA_W-1:0]      din_q1;
    logic [`IOB_DATA_W-1:0]      din_q2;
  } iob_top_state_t;

  typedef struct packed {
    logic [`IOB_DATA_W-1:0] hold;
    logic [1:0]             cnt;
  } iob_pack_state_t;

endpackage : iob_pkg

// ### include/iob_pack_if.sv
`timescale 1ns/1ps
`include "iob_defines.svh"

interface iob_pack_if;
  logic                          clear;
  logic                          push;
  logic [`IOB_IO_BYTE_W-1:0]     byte_in;
  logic                          load;
  logic [`IOB_DATA_W-1:0]        word_in;
  logic                          pop;
  logic [`IOB_DATA_W-1:0]        word_out;
  logic [`IOB_IO_BYTE_W-1:0]     byte_out;
  logic [1:0]                    cnt;

  modport packer (input clear, push, byte_in, load, word_in, pop,
                  output word_out, byte_out, cnt);
  modport user   (output clear, push, byte_in, load, word_in, pop,
                  input word_out, byte_out, cnt);
endinterface : iob_pack_if

// ### logic/iob_pack.sv
`timescale 1ns/1ps
`include "iob_defines.svh"

module iob_pack (
  input  wire logic   sys_clk,
  input  wire logic   rst_n,
  iob_pack_if.packer  pk
);
  import iob_pkg::*;

  iob_pack_state_t s_r;
  iob_pack_state_t s_nxt;

  // one shift register serves both packing and unpacking, high byte first
  always_comb begin
    s_nxt = s_r;
    if (pk.clear) begin
      s_nxt.cnt = 2'd0;
    end else if (pk.load) begin
      s_nxt.hold = pk.word_in;
      s_nxt.cnt  = 2'd2;
    end else if (pk.push) begin
      s_nxt.hold = {s_r.hold[`IOB_IO_BYTE_W-1:0], pk.byte_in};
      s_nxt.cnt  = s_r.cnt + 2'd1;
    end else if (pk.pop) begin
      s_nxt.hold = {s_r.hold[`IOB_IO_BYTE_W-1:0], 8'h00};
      s_nxt.cnt  = s_r.cnt - 2'd1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // an odd final byte lands in the high half, low half zero
  assign pk.word_out = (s_r.cnt == 2'd1) ? {s_r.hold[7:0], 8'h00} : s_r.hold;
  assign pk.byte_out = s_r.hold[15:8];
  assign pk.cnt      = s_r.cnt;

endmodule : iob_pack

// ### logic/iob_top.sv
`timescale 1ns/1ps
`include "iob_defines.svh"
// Notes on behaviour
// - sixteen address lines, driven only by owner
// - memory location on low fifteen lines
// - top address line selects word or byte
// - I/O address and function on low byte
// - lines 7..3 device, 2..0 function
// - block count from index, interrupts held off
// - DMA steals cycles between processor cycles
// - word and byte transfers, automatic packing
// - transfers via A, X or memory
// - shared data bus, driven during own write

module iob_top #(
  parameter int DEV_W = `IOB_DEV_W
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  input  wire logic                          req_valid,
  input  wire iob_pkg::iob_op_t              req_op,
  input  wire logic [`IOB_MEM_ADDR_W-1:0]    req_addr,
  input  wire logic                          req_byte,
  input  wire logic                          req_pack,
  input  wire logic [DEV_W-1:0]              req_dev,
  input  wire logic [`IOB_IO_BYTE_W-DEV_W-1:0] req_fc,
  input  wire logic [`IOB_DATA_W-1:0]        req_wdata,
  input  wire logic                          req_reg_sel,
  input  wire logic [15:0]                   req_count,
  input  wire logic                          req_eob,
  output logic                               req_ready,
  output logic                               done,
  output logic [`IOB_DATA_W-1:0]             rdata,
  output logic [`IOB_DATA_W-1:0]             work_a,
  output logic [`IOB_DATA_W-1:0]             work_x,
  output logic                               sense_flag,
  output logic                               irq_inhibit,
  output logic                               dma_grant,
  output logic [`IOB_ADDR_W-1:0]             addr_out,
  output logic                               addr_oe_n,
  input  wire logic [`IOB_DATA_W-1:0]        data_in,
  output logic [`IOB_DATA_W-1:0]             data_out,
  output logic                               data_oe_n,
  output logic                               select_cmd_strobe_n,
  output logic                               in_cmd_n,
  output logic                               out_cmd_n,
  output logic                               transfer_strobe_pulse_n,
  output logic                               mem_rd_n,
  output logic                               mem_wr_n,
  output logic                               echo_n,
  input  wire logic                          sense_response_line_n,
  input  wire logic                          dma_stop_n
);
  import iob_pkg::*;

  // refuse a split that leaves no room for a function code
  if (DEV_W < 1 || DEV_W > 7) begin : g_bad_dev_w
    $error("iob_top: DEV_W must lie in 1..7");
  end

  localparam logic [`IOB_TIMER_W-1:0] SETUP_T  = `IOB_TIMER_W'(`IOB_SETUP_CYC - 1);
  localparam logic [`IOB_TIMER_W-1:0] STROBE_T = `IOB_TIMER_W'(`IOB_STROBE_CYC - 1);
  localparam logic [`IOB_TIMER_W-1:0] HOLD_T   = `IOB_TIMER_W'(`IOB_HOLD_CYC - 1);

  iob_top_state_t s_r;
  iob_top_state_t s_nxt;
  iob_pack_if     pk ();
  logic           blk;
  logic           packed_b;
  logic           last;

  iob_pack u_pack (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pk      (pk.packer)
  );

  assign blk      = (s_r.op == IOB_OP_BLK_IN) || (s_r.op == IOB_OP_BLK_OUT);
  assign packed_b = s_r.pack && s_r.byte_m;
  assign last     = (s_r.count == 16'h0001);
  assign pk.byte_in = s_r.rdata[7:0];
  assign pk.word_in = s_r.rdata;

  // main sequencer: one bus cycle is setup, strobe, hold
  always_comb begin
    s_nxt = s_r;
    pk.clear = 1'b0;
    pk.push  = 1'b0;
    pk.load  = 1'b0;
    pk.pop   = 1'b0;
    s_nxt.done   = 1'b0;
    s_nxt.echo_n = 1'b1;
    // pins pass two flops before anything looks at them
    s_nxt.dma_q1 = ~dma_stop_n;
    s_nxt.dma_q2 = s_r.dma_q1;
    s_nxt.ser_q1 = ~sense_response_line_n;
    s_nxt.ser_q2 = s_r.ser_q1;
    s_nxt.din_q1 = data_in;
    s_nxt.din_q2 = s_r.din_q1;
    case (s_r.st)
      IOB_ST_IDLE: begin
        if (s_r.dma_q2) begin
          s_nxt.grant = 1'b1;
          s_nxt.ready = 1'b0;
          s_nxt.st    = IOB_ST_DMA;
        end else if (req_valid && s_r.ready) begin
          s_nxt.ready     = 1'b0;
          s_nxt.op        = req_op;
          s_nxt.byte_m    = req_byte;
          s_nxt.pack      = req_pack;
          s_nxt.eob       = req_eob;
          s_nxt.reg_sel   = req_reg_sel;
          s_nxt.mem_a     = req_addr;
          s_nxt.wdata     = req_wdata;
          s_nxt.io_sel    = {req_dev, req_fc};
          s_nxt.count     = req_count;
          s_nxt.phase_mem = (req_op == IOB_OP_BLK_OUT);
          pk.clear        = 1'b1;
          if ((req_op == IOB_OP_BLK_IN || req_op == IOB_OP_BLK_OUT) && req_count == 16'h0000) begin
            s_nxt.ready = 1'b1;
            s_nxt.done  = 1'b1;
          end else begin
            // no interrupts while a block moves
            s_nxt.irq_inh = (req_op == IOB_OP_BLK_IN) || (req_op == IOB_OP_BLK_OUT);
            s_nxt.st      = IOB_ST_ISSUE;
          end
        end
      end
      IOB_ST_ISSUE: begin
        s_nxt.cur_io = !blk ? !(s_r.op == IOB_OP_MEM_RD || s_r.op == IOB_OP_MEM_WR)
                            : !s_r.phase_mem;
        s_nxt.cur_wr = (s_r.op == IOB_OP_MEM_WR) || (s_r.op == IOB_OP_IO_OUT)
                     || (s_r.op == IOB_OP_BLK_IN && s_r.phase_mem)
                     || (s_r.op == IOB_OP_BLK_OUT && !s_r.phase_mem);
        if (s_nxt.cur_io) begin
          // upper byte left at zero on I/O
          s_nxt.addr = {8'h00, s_r.io_sel};
        end else begin
          s_nxt.addr = {s_r.byte_m, s_r.mem_a};
        end
        if (s_r.op == IOB_OP_BLK_IN && s_r.phase_mem && packed_b) begin
          // packed word from the byte packer
          s_nxt.dout = pk.word_out;
        end else if (s_r.op == IOB_OP_BLK_OUT && packed_b) begin
          s_nxt.dout = {8'h00, pk.byte_out};
        end else begin
          s_nxt.dout = s_r.wdata;
        end
        // drive address, and data only when writing
        s_nxt.addr_oe_n = 1'b0;
        s_nxt.dout_oe_n = ~s_nxt.cur_wr;
        // command level frames the whole cycle
        s_nxt.sel_n = ~(s_r.op == IOB_OP_SELECT);
        s_nxt.in_n  = ~(s_nxt.cur_io && !s_nxt.cur_wr && s_r.op != IOB_OP_SELECT
                        && s_r.op != IOB_OP_SENSE);
        s_nxt.out_n = ~(s_nxt.cur_io && s_nxt.cur_wr);
        s_nxt.timer = SETUP_T;
        s_nxt.st    = IOB_ST_SETUP;
      end
      IOB_ST_SETUP: begin
        s_nxt.timer = s_r.timer - 1'b1;
        if (s_r.timer == '0) begin
          // strobe only where an interface acts on it
          s_nxt.pulse_n = ~(s_r.cur_io && s_r.op != IOB_OP_SENSE);
          s_nxt.mrd_n   = ~(!s_r.cur_io && !s_r.cur_wr);
          s_nxt.mwr_n   = ~(!s_r.cur_io && s_r.cur_wr);
          s_nxt.timer   = STROBE_T;
          s_nxt.st      = IOB_ST_STROBE;
        end
      end
      IOB_ST_STROBE: begin
        s_nxt.timer = s_r.timer - 1'b1;
        if (s_r.timer == '0) begin
          // sample at the trailing edge, after two sync stages have settled
          s_nxt.rdata = s_r.din_q2;
          if (s_r.op == IOB_OP_SENSE) begin
            s_nxt.sense = s_r.ser_q2;
          end
          s_nxt.pulse_n = 1'b1;
          s_nxt.mrd_n   = 1'b1;
          s_nxt.mwr_n   = 1'b1;
          s_nxt.timer   = HOLD_T;
          s_nxt.st      = IOB_ST_HOLD;
        end
      end
      IOB_ST_HOLD: begin
        s_nxt.timer = s_r.timer - 1'b1;
        if (s_r.timer == '0) begin
          s_nxt.sel_n     = 1'b1;
          s_nxt.in_n      = 1'b1;
          s_nxt.out_n     = 1'b1;
          s_nxt.dout_oe_n = 1'b1;
          s_nxt.st        = IOB_ST_ISSUE;
          if (!blk) begin
            // result into A or X
            if (s_r.op == IOB_OP_IO_IN || s_r.op == IOB_OP_MEM_RD) begin
              if (s_r.reg_sel) begin
                s_nxt.work_x = s_r.rdata;
              end else begin
                s_nxt.work_a = s_r.rdata;
              end
            end
            s_nxt.st = IOB_ST_IDLE;
          end else if (s_r.op == IOB_OP_BLK_IN) begin
            if (!s_r.phase_mem) begin
              s_nxt.count = s_r.count - 16'h0001;
              pk.push = packed_b;
              s_nxt.wdata = s_r.rdata;
              s_nxt.phase_mem = !packed_b || pk.cnt == 2'd1 || last;
            end else begin
              s_nxt.mem_a     = s_r.mem_a + 1'b1;
              s_nxt.phase_mem = 1'b0;
              pk.clear        = 1'b1;
              if (s_r.count == 16'h0000) begin
                s_nxt.st = IOB_ST_IDLE;
              end
            end
          end else begin
            if (s_r.phase_mem) begin
              s_nxt.mem_a     = s_r.mem_a + 1'b1;
              s_nxt.wdata     = s_r.rdata;
              pk.load         = packed_b;
              s_nxt.phase_mem = 1'b0;
            end else begin
              s_nxt.count = s_r.count - 16'h0001;
              pk.pop      = packed_b;
              s_nxt.phase_mem = !packed_b || pk.cnt == 2'd1;
              if (last) begin
                s_nxt.st = IOB_ST_IDLE;
              end
            end
          end
          if (s_nxt.st == IOB_ST_IDLE) begin
            s_nxt.addr_oe_n = 1'b1;
            s_nxt.ready     = 1'b1;
            s_nxt.done      = 1'b1;
            s_nxt.irq_inh   = 1'b0;
            s_nxt.echo_n    = ~(blk && s_r.eob);
          end else if (s_r.dma_q2) begin
            // steal a cycle between the bus cycles of a block, mid-item included
            s_nxt.addr_oe_n = 1'b1;
            s_nxt.grant     = 1'b1;
            s_nxt.st        = IOB_ST_DMA;
          end
        end
      end
      IOB_ST_DMA: begin
        // bus released while DMA owns it
        s_nxt.addr_oe_n = 1'b1;
        s_nxt.dout_oe_n = 1'b1;
        if (!s_r.dma_q2) begin
          s_nxt.grant = 1'b0;
          // only a block can be cut; a steal taken in idle must not replay the last op
          s_nxt.ready = !s_r.irq_inh;
          s_nxt.st    = s_r.irq_inh ? IOB_ST_ISSUE : IOB_ST_IDLE;
        end
      end
      default: begin
        s_nxt.st = IOB_ST_IDLE;
      end
    endcase
  end

  // all state in one register; strobes idle high
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r           <= '0;
      s_r.st        <= IOB_ST_IDLE;
      s_r.ready     <= 1'b1;
      s_r.addr_oe_n <= 1'b1;
      s_r.dout_oe_n <= 1'b1;
      s_r.sel_n     <= 1'b1;
      s_r.in_n      <= 1'b1;
      s_r.out_n     <= 1'b1;
      s_r.pulse_n   <= 1'b1;
      s_r.mrd_n     <= 1'b1;
      s_r.mwr_n     <= 1'b1;
      s_r.echo_n    <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign req_ready               = s_r.ready;
  assign done                    = s_r.done;
  assign rdata                   = s_r.rdata;
  assign work_a                  = s_r.work_a;
  assign work_x                  = s_r.work_x;
  assign sense_flag              = s_r.sense;
  assign irq_inhibit             = s_r.irq_inh;
  assign dma_grant               = s_r.grant;
  assign addr_out                = s_r.addr;
  assign addr_oe_n               = s_r.addr_oe_n;
  assign data_out                = s_r.dout;
  assign data_oe_n               = s_r.dout_oe_n;
  assign select_cmd_strobe_n     = s_r.sel_n;
  assign in_cmd_n                = s_r.in_n;
  assign out_cmd_n               = s_r.out_n;
  assign transfer_strobe_pulse_n = s_r.pulse_n;
  assign mem_rd_n                = s_r.mrd_n;
  assign mem_wr_n                = s_r.mwr_n;
  assign echo_n                  = s_r.echo_n;

endmodule : iob_top

// ### test/iob_sva.sv
`timescale 1ns/1ps
`include "iob_defines.svh"

module iob_sva #(
  parameter int DEV_W = 5
) (
  input wire logic                   sys_clk,
  input wire logic                   rst_n,
  input wire logic                   req_ready,
  input wire logic                   done,
  input wire logic                   dma_grant,
  input wire logic [`IOB_ADDR_W-1:0] addr_out,
  input wire logic                   addr_oe_n,
  input wire logic                   data_oe_n,
  input wire logic                   select_cmd_strobe_n,
  input wire logic                   in_cmd_n,
  input wire logic                   out_cmd_n,
  input wire logic                   transfer_strobe_pulse_n,
  input wire logic                   mem_rd_n,
  input wire logic                   mem_wr_n,
  input wire logic                   echo_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic io_cmd;

  // any of the three i/o command levels active
  assign io_cmd = !select_cmd_strobe_n || !in_cmd_n || !out_cmd_n;

  // strobe is a multi-cycle phase, never a glitch
  sequence strobe_start;
    $fell(transfer_strobe_pulse_n);
  endsequence
  sequence strobe_body;
    !transfer_strobe_pulse_n [*8];
  endsequence

  io_hi_byte_a: assert property (io_cmd && !addr_oe_n |-> addr_out[15:8] == 8'h00)
    else $error("upper address byte not zero on i/o cycle");
  cmd_onehot_a: assert property ($onehot0({~select_cmd_strobe_n, ~in_cmd_n, ~out_cmd_n, ~mem_rd_n, ~mem_wr_n}))
    else $error("two bus commands active together");
  strobe_addr_a: assert property (!transfer_strobe_pulse_n |-> !addr_oe_n)
    else $error("strobe without driven address");
  strobe_width_a: assert property (strobe_start |-> strobe_body)
    else $error("strobe too short");
  grant_release_a: assert property (dma_grant |-> addr_oe_n && data_oe_n)
    else $error("bus driven while dma owns it");
  echo_pulse_a: assert property ($fell(echo_n) |=> echo_n && req_ready)
    else $error("echo wider than one cycle");
  done_ready_a: assert property (done |-> req_ready ##1 !done)
    else $error("done not a single pulse with ready");
  addr_hold_a: assert property (!in_cmd_n && $past(!in_cmd_n) |-> $stable(addr_out))
    else $error("address moved during input command");
  data_own_a: assert property (!data_oe_n |-> in_cmd_n && mem_rd_n)
    else $error("data driven during a read");
  mem_addr_a: assert property (!mem_rd_n || !mem_wr_n |-> !addr_oe_n)
    else $error("memory command without address");
endmodule : iob_sva

bind iob_top iob_sva #(.DEV_W(DEV_W)) u_sva (
  .sys_clk(sys_clk), .rst_n(rst_n), .req_ready(req_ready), .done(done),
  .dma_grant(dma_grant), .addr_out(addr_out), .addr_oe_n(addr_oe_n), .data_oe_n(data_oe_n),
  .select_cmd_strobe_n(select_cmd_strobe_n), .in_cmd_n(in_cmd_n), .out_cmd_n(out_cmd_n),
  .transfer_strobe_pulse_n(transfer_strobe_pulse_n), .mem_rd_n(mem_rd_n),
  .mem_wr_n(mem_wr_n), .echo_n(echo_n)
);

// ### test/iob_periph.sv
`timescale 1ns/1ps

module iob_periph #(
  parameter logic [4:0] MY_DEV = 5'h0A
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] addr_out,
  input  wire logic        addr_oe_n,
  input  wire logic [15:0] data_out,
  input  wire logic        select_cmd_strobe_n,
  input  wire logic        in_cmd_n,
  input  wire logic        out_cmd_n,
  input  wire logic        transfer_strobe_pulse_n,
  input  wire logic        mem_rd_n,
  input  wire logic        mem_wr_n,
  input  wire logic        echo_n,
  input  wire logic        stat,
  output logic [15:0]      data_in,
  output logic             sense_response_line_n
);
  logic [15:0] mem [16];
  logic [15:0] dev_reg, last_wr, last_a, rel_d;
  logic [7:0]  in_cnt;
  logic [2:0]  mode_r;
  logic        eob_r, hit, pls_q, mwr_q;

  assign hit = !addr_oe_n && addr_out[7:3] == MY_DEV;
  // drive device data when addressed, memory data on read; otherwise a changing pattern
  always_comb begin
    if (hit && !in_cmd_n) data_in = 16'h5A00 + {8'h00, in_cnt};
    else if (!mem_rd_n) data_in = mem[addr_out[3:0]];
    else data_in = ~rel_d;
  end
  // status while addressed, line pulled up otherwise
  assign sense_response_line_n = !(hit && stat);

  // trailing edges of strobe and memory write do the loading
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {dev_reg, last_wr, last_a, rel_d, in_cnt, mode_r, eob_r} <= '0;
      {pls_q, mwr_q} <= 2'h3;
    end else begin
      rel_d <= data_in;
      pls_q <= transfer_strobe_pulse_n;
      mwr_q <= mem_wr_n;
      if (!addr_oe_n) last_a <= addr_out;
      // strobe loads output, steps the input count, select sets mode and clears eob
      if (!pls_q && transfer_strobe_pulse_n && hit) begin
        if (!out_cmd_n) dev_reg <= data_out;
        if (!in_cmd_n) in_cnt <= in_cnt + 8'h01;
        if (!select_cmd_strobe_n) begin
          mode_r <= addr_out[2:0];
          eob_r <= 1'b0;
        end
      end
      if (!echo_n) eob_r <= 1'b1;
      if (!mwr_q && mem_wr_n) begin
        mem[addr_out[3:0]] <= data_out;
        last_wr <= data_out;
      end
    end
  end
endmodule : iob_periph

// ### test/iob_top_tb.sv
`timescale 1ns/1ps
`include "iob_defines.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module iob_top_tb;
  import iob_pkg::*;
  localparam logic [4:0] DEV = 5'h0A;
  logic        sys_clk, rst_n, req_valid, req_byte, req_pack, req_reg_sel, req_eob;
  logic        stat, dma_stop_n, req_ready, done, sense_flag, irq_inhibit, dma_grant;
  logic        addr_oe_n, data_oe_n, sel_n, in_n, out_n, pls_n, mrd_n, mwr_n, echo_n, ser_n;
  iob_op_t     req_op;
  logic [14:0] req_addr;
  logic [4:0]  req_dev;
  logic [2:0]  req_fc;
  logic [15:0] req_wdata, req_count, rdata, work_a, work_x, addr_out, data_in, data_out, xp;
  int          error_cnt, n_tests;

  iob_top dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req_op(req_op),
    .req_addr(req_addr), .req_byte(req_byte), .req_pack(req_pack), .req_dev(req_dev),
    .req_fc(req_fc), .req_wdata(req_wdata), .req_reg_sel(req_reg_sel), .req_count(req_count),
    .req_eob(req_eob), .req_ready(req_ready), .done(done), .rdata(rdata), .work_a(work_a),
    .work_x(work_x), .sense_flag(sense_flag), .irq_inhibit(irq_inhibit), .dma_grant(dma_grant),
    .addr_out(addr_out), .addr_oe_n(addr_oe_n), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .select_cmd_strobe_n(sel_n), .in_cmd_n(in_n), .out_cmd_n(out_n),
    .transfer_strobe_pulse_n(pls_n), .mem_rd_n(mrd_n), .mem_wr_n(mwr_n), .echo_n(echo_n),
    .sense_response_line_n(ser_n), .dma_stop_n(dma_stop_n)
  );
  iob_periph #(.MY_DEV(DEV)) per (
    .sys_clk(sys_clk), .rst_n(rst_n), .addr_out(addr_out), .addr_oe_n(addr_oe_n),
    .data_out(data_out), .select_cmd_strobe_n(sel_n), .in_cmd_n(in_n), .out_cmd_n(out_n),
    .transfer_strobe_pulse_n(pls_n), .mem_rd_n(mrd_n), .mem_wr_n(mwr_n), .echo_n(echo_n),
    .stat(stat), .data_in(data_in), .sense_response_line_n(ser_n)
  );

  // 8 ns clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  // one-cycle request at the falling edge, ready is high whenever we call this
  task automatic start(input iob_op_t op, input logic [14:0] a, input logic [15:0] w,
                       input logic [15:0] c);
    @(negedge sys_clk);
    req_op = op;
    req_addr = a;
    req_wdata = w;
    req_count = c;
    req_valid = 1'b1;
    @(negedge sys_clk);
    req_valid = 1'b0;
  endtask : start

  // bounded wait, a block of two items takes four bus cycles
  task automatic wait_done;
    int k;
    k = 0;
    while (done !== 1'b1 && k < 1500) begin
      @(negedge sys_clk);
      k++;
    end
    `CHK(k < 1500, 1'b1)
    @(negedge sys_clk);
  endtask : wait_done

  task automatic run(input iob_op_t op, input logic [14:0] a, input logic [15:0] w);
    start(op, a, w, 16'h0000);
    wait_done();
  endtask : run

  task automatic t_mem;
    run(IOB_OP_MEM_WR, 15'h0005, 16'hA55A);
    `CHK(per.last_a, 16'h0005)
    run(IOB_OP_MEM_RD, 15'h0005, 16'h0000);
    `CHK(work_a, 16'hA55A)
    `CHK(rdata, 16'hA55A)
    req_byte = 1'b1;
    run(IOB_OP_MEM_RD, 15'h0005, 16'h0000);
    `CHK(per.last_a, 16'h8005)
    req_byte = 1'b0;
    $display("t_mem end");
  endtask : t_mem

  task automatic t_io;
    req_fc = 3'h5;
    run(IOB_OP_IO_OUT, 15'h7FFF, 16'h1234);
    `CHK(per.dev_reg, 16'h1234)
    `CHK(per.last_a, {8'h00, DEV, 3'h5})
    // another device address must leave the interface untouched
    req_dev = 5'h03;
    run(IOB_OP_IO_OUT, 15'h0000, 16'h4321);
    `CHK(per.dev_reg, 16'h1234)
    req_dev = DEV;
    xp = 16'h5A00 + {8'h00, per.in_cnt};
    req_reg_sel = 1'b1;
    run(IOB_OP_IO_IN, 15'h0000, 16'h0000);
    `CHK(work_x, xp)
    for (int s = 0; s < 2; s++) begin
      stat = s[0];
      run(IOB_OP_SENSE, 15'h0000, 16'h0000);
      `CHK(sense_flag, s[0])
    end
    $display("t_io end");
  endtask : t_io

  // block in with end-of-block echo, then packed bytes
  task automatic t_blk;
    req_eob = 1'b1;
    xp = 16'h5A00 + {8'h00, per.in_cnt};
    start(IOB_OP_BLK_IN, 15'h0008, 16'h0000, 16'h0002);
    repeat (4) @(negedge sys_clk);
    `CHK(irq_inhibit, 1'b1)
    wait_done();
    `CHK(irq_inhibit, 1'b0)
    `CHK(per.mem[8], xp)
    `CHK(per.mem[9], xp + 16'h0001)
    `CHK(per.eob_r, 1'b1)
    req_eob = 1'b0;
    req_byte = 1'b1;
    req_pack = 1'b1;
    xp = {per.in_cnt, per.in_cnt + 8'h01};
    start(IOB_OP_BLK_IN, 15'h0002, 16'h0000, 16'h0002);
    wait_done();
    `CHK(per.last_wr, xp)
    // packed block out: high byte first, so the low byte is left last
    xp = {8'h00, per.last_wr[7:0]};
    start(IOB_OP_BLK_OUT, 15'h0002, 16'h0000, 16'h0002);
    wait_done();
    `CHK(per.dev_reg, xp)
    req_byte = 1'b0;
    req_pack = 1'b0;
    $display("t_blk end");
  endtask : t_blk

  // select every function code, which also clears the end-of-block latch
  task automatic t_sel;
    for (int f = 0; f < 8; f++) begin
      req_fc = f[2:0];
      run(IOB_OP_SELECT, 15'h0000, 16'h0000);
      `CHK(per.mode_r, f[2:0])
      `CHK(per.eob_r, 1'b0)
    end
    $display("t_sel end");
  endtask : t_sel

  // stop in mid-block: bus released, block resumes afterwards
  task automatic t_dma;
    int k;
    xp = per.mem[9];
    start(IOB_OP_BLK_OUT, 15'h0008, 16'h0000, 16'h0002);
    repeat (60) @(negedge sys_clk);
    dma_stop_n = 1'b0;
    k = 0;
    while (dma_grant !== 1'b1 && k < 200) begin
      @(negedge sys_clk);
      k++;
    end
    `CHK(dma_grant, 1'b1)
    `CHK(addr_oe_n, 1'b1)
    repeat (20) @(negedge sys_clk);
    dma_stop_n = 1'b1;
    wait_done();
    `CHK(per.dev_reg, xp)
    // a steal while idle must hand back a ready, idle bus
    dma_stop_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    `CHK({dma_grant, req_ready}, 2'b10)
    dma_stop_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    `CHK({dma_grant, req_ready}, 2'b01)
    $display("t_dma end");
  endtask : t_dma

  // watchdog, well past the few thousand cycles the tests need
  initial begin
    #320000;
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end

  initial begin
    {error_cnt, n_tests} = '0;
    {req_valid, req_byte, req_pack, req_reg_sel, req_eob, stat} = '0;
    {rst_n, dma_stop_n} = 2'h1;
    req_op = IOB_OP_MEM_RD;
    {req_addr, req_fc, req_wdata, req_count} = '0;
    req_dev = DEV;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    `CHK(req_ready, 1'b1)
    `CHK(data_oe_n, 1'b1)
    t_mem();
    t_io();
    t_blk();
    t_sel();
    t_dma();
    test_done();
  end
endmodule : iob_top_tb
